// File: core/cpc_ctrl.sv
// module: pin-level control logic of a one-cell charger
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - disable pin high stops charge, high impedance
// - disable toggle restarts safety timer only default
// - usb select high gives 100 mA input
// - adapter select: no input limit, 1 A
// - indicator low while charging or during a fault pulse, released otherwise
// - a fault outside a running pulse gives one 128 us pulse
// - indicator works only when enable bit set
// - accessory output follows its enable bit
// - default mode: cold or hot suspends charge
// - default mode: warm reduces current; faults reported
// - host mode: temperature faults only reported
// - watchdog expiry before safety expiry enters default
// - default entry resets registers, restarts safety timer
module cpc_ctrl
   import cpc_pkg::*;
#(
   parameter longint unsigned SAFETY_LEN = SAFETY_CYC,
   parameter longint unsigned WDOG_LEN   = WDOG_CYC,
   parameter int unsigned     PULSE_LEN  = FAULT_PULSE_CYC
)(
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        charge_disable_pin,    // pin: high disables
   input  wire logic        source_select_pin,     // pin: high usb, low adapter
   input  wire logic        pack_temp_cold,        // comparator: cold
   input  wire logic        pack_temp_hot,         // comparator: hot
   input  wire logic        pack_temp_warm,        // comparator: warm
   input  wire logic        fault_event,           // other faults, one-cycle
   input  wire logic        charge_done,           // termination reached
   input  wire logic        indicator_en,          // control bit, enables indicator
   input  wire logic        accessory_en,          // control bit, accessory switch
   input  wire logic        wdog_kick,             // i2c access, one-cycle
   input  wire logic        host_write,            // i2c write exits default mode
   output logic             charging,              // charge in progress
   output logic             hi_z_mode,             // high impedance mode
   output logic [3:0]       input_limit,           // input current limit code
   output logic [3:0]       charge_current,        // charge current code
   output logic             indicator_o,           // indicator pin output value
   output logic             indicator_oe,          // indicator drive enable (pull low)
   output logic             accessory_power_output,// pass switch on
   output logic             default_mode,          // 1 default, 0 host
   output logic             safety_expired,        // safety timer ran out
   output logic [1:0]       temp_status,           // reported zone
   output logic             regs_reset             // one-cycle: registers to defaults
);
   import cpc_pkg::*;

   // ****************************************************************
   // input synchronisers
   // ****************************************************************
   logic [4:0] sync1_r;   // first stage
   logic [4:0] sync2_r;   // second stage
   logic       cd_prev_r; // last synced disable level

   // two-stage capture of the asynchronous pins
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
      end else begin
         sync1_r <= {charge_disable_pin, source_select_pin, pack_temp_cold,
                     pack_temp_hot, pack_temp_warm};
         sync2_r <= sync1_r;
      end
   end

   // second-stage taps, the only readers of the synchronised pins
   logic cd_s, psel_s, cold_s, hot_s, warm_s;
   assign cd_s   = sync2_r[4];
   assign psel_s = sync2_r[3];
   assign cold_s = sync2_r[2];
   assign hot_s  = sync2_r[1];
   assign warm_s = sync2_r[0];

   // previous disable level, reset to the pulled-down idle level
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cd_prev_r <= 1'b0;
      end else begin
         cd_prev_r <= cd_s;
      end
   end

   logic cd_toggle;   // any edge of the disable pin
   assign cd_toggle = cd_s ^ cd_prev_r;

   // ****************************************************************
   // temperature classification
   // ****************************************************************
   function automatic cpc_temp_e classify(input logic c, input logic h, input logic w);
      if (c) begin
         return CPC_T_COLD;
      end else if (h) begin
         return CPC_T_HOT;
      end else if (w) begin
         return CPC_T_WARM;
      end
      return CPC_T_NORMAL;
   endfunction : classify

   cpc_temp_e zone;
   assign zone = classify(cold_s, hot_s, warm_s);

   logic [1:0] zone_prev_r;   // for fault edge detection
   // zone history and the reported zone
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         zone_prev_r <= 2'b00;
         temp_status <= 2'b00;
      end else begin
         zone_prev_r <= zone;
         temp_status <= zone;
      end
   end

   logic temp_fault_new;   // entry into a non-normal zone
   assign temp_fault_new = (zone != CPC_T_NORMAL) && (zone != cpc_temp_e'(zone_prev_r));

   // ****************************************************************
   // watchdog and mode
   // ****************************************************************
   logic [63:0] wdog_r;     // watchdog count
   logic [63:0] safety_r;   // safety count
   logic        wdog_exp;
   logic        enter_default;
   logic        mode_r;     // 1 default

   // last count of the watchdog span
   assign wdog_exp = (wdog_r == WDOG_LEN - 64'd1);

   // watchdog runs in host mode only; any i2c access clears it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wdog_r <= 64'h0000_0000_0000_0000;
      end else if (wdog_kick || mode_r) begin
         wdog_r <= 64'h0000_0000_0000_0000;
      end else if (!wdog_exp) begin
         wdog_r <= wdog_r + 64'd1;
      end
   end

   // host silence with the safety timer still running falls back to default
   assign enter_default = !mode_r && wdog_exp && !safety_expired;

   // mode flag: default entry beats a host write in the same cycle
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_r <= 1'b1;
      end else if (enter_default) begin
         mode_r <= 1'b1;
      end else if (host_write) begin
         mode_r <= 1'b0;
      end
   end

   // registered copies of mode and the register-reset strobe
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         default_mode <= 1'b1;
         regs_reset   <= 1'b0;
      end else begin
         default_mode <= mode_r;
         regs_reset   <= enter_default;
      end
   end

   // ****************************************************************
   // safety timer
   // ****************************************************************
   logic safety_restart;
   assign safety_restart = enter_default || (cd_toggle && mode_r);

   // safety count advances only while charging and stops at expiry
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         safety_r       <= 64'h0000_0000_0000_0000;
         safety_expired <= 1'b0;
      end else if (safety_restart) begin
         safety_r       <= 64'h0000_0000_0000_0000;
         safety_expired <= 1'b0;
      end else if (charging && !safety_expired) begin
         if (safety_r == SAFETY_LEN - 64'd1) begin
            safety_expired <= 1'b1;
         end else begin
            safety_r <= safety_r + 64'd1;
         end
      end
   end

   // ****************************************************************
   // charge control and limits
   // ****************************************************************
   logic temp_suspend;   // default mode only
   assign temp_suspend = mode_r && ((zone == CPC_T_COLD) || (zone == CPC_T_HOT));

   // charge enable and high impedance mode from the synced pin
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         charging  <= 1'b0;
         hi_z_mode <= 1'b1;
      end else begin
         hi_z_mode <= cd_s;
         charging  <= !cd_s && !charge_done && !temp_suspend && !safety_expired;
      end
   end

   // start-up limits from the source pin, reduced current when warm in default mode
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         input_limit    <= ILIM_100MA;
         charge_current <= ICHG_1A;
      end else begin
         input_limit    <= psel_s ? ILIM_100MA : ILIM_NONE;
         if (mode_r && zone == CPC_T_WARM) begin
            charge_current <= ICHG_REDUCED;
         end else begin
            charge_current <= ICHG_1A;
         end
      end
   end

   // ****************************************************************
   // indicator and accessory switch
   // ****************************************************************
   cpc_pulse_if pif ();
   // any fault or entry into a non-normal temperature zone requests one pulse
   assign pif.fire = fault_event || temp_fault_new;

   cpc_pulse_gen #(.PULSE_CYC(PULSE_LEN)) u_pulse (
      .core_clk (core_clk),
      .rstn     (rstn),
      .pif      (pif.timer)
   );

   // open-drain drive: the pin is pulled low whenever the enable is high
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         indicator_o  <= 1'b0;
         indicator_oe <= 1'b0;
      end else begin
         indicator_o  <= 1'b0;
         // fault pulse overrides the charge level; pulse is a low drive
         indicator_oe <= indicator_en && (pif.active || charging);
      end
   end

   // accessory pass switch follows its control bit
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         accessory_power_output <= 1'b0;
      end else begin
         accessory_power_output <= accessory_en;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   // default entry: mode flag and register strobe rise together
   sequence s_default_taken;
      mode_r && regs_reset;
   endsequence
   // pulse launch: timer busy on the following cycle
   sequence s_pulse_busy;
      pif.active;
   endsequence
   a_disable_hiz: assert property (@(posedge core_clk) disable iff (!rstn)
      hi_z_mode |-> !charging)
      else $error("charging while disabled");
   a_ind_gated: assert property (@(posedge core_clk) disable iff (!rstn)
      !$past(indicator_en) |-> !indicator_oe)
      else $error("indicator active while off");
   a_acc_follow: assert property (@(posedge core_clk) disable iff (!rstn)
      accessory_power_output == $past(accessory_en))
      else $error("accessory mismatch");
   a_host_temp: assert property (@(posedge core_clk) disable iff (!rstn)
      !mode_r |=> charge_current == ICHG_1A)
      else $error("host mode current changed");
   a_wdog_default: assert property (@(posedge core_clk) disable iff (!rstn)
      enter_default |=> s_default_taken)
      else $error("default entry missed");
   a_safety_restart: assert property (@(posedge core_clk) disable iff (!rstn)
      safety_restart |=> !safety_expired && safety_r == 64'd0)
      else $error("safety not restarted");
   a_psel_limit: assert property (@(posedge core_clk) disable iff (!rstn)
      psel_s |=> input_limit == ILIM_100MA)
      else $error("usb limit wrong");
   a_hot_suspend: assert property (@(posedge core_clk) disable iff (!rstn)
      temp_suspend |=> !charging)
      else $error("charging while hot or cold");
   a_pulse_start: assert property (@(posedge core_clk) disable iff (!rstn)
      pif.fire && !pif.active |=> s_pulse_busy)
      else $error("fault pulse not started");
   a_ind_charge: assert property (@(posedge core_clk) disable iff (!rstn)
      indicator_en && charging |=> indicator_oe)
      else $error("indicator idle while charging");
   a_limit_adapter: assert property (@(posedge core_clk) disable iff (!rstn)
      !psel_s |=> input_limit == ILIM_NONE)
      else $error("adapter limit wrong");
   a_warm_reduce: assert property (@(posedge core_clk) disable iff (!rstn)
      mode_r && zone == CPC_T_WARM |=> charge_current == ICHG_REDUCED)
      else $error("warm current not reduced");
   a_host_keep: assert property (@(posedge core_clk) disable iff (!rstn)
      !mode_r && !enter_default && safety_r != 64'd0 |=> safety_r != 64'd0)
      else $error("safety restarted in host mode");
   a_regs_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
      regs_reset |=> !regs_reset)
      else $error("register reset strobe too long");
endmodule : cpc_ctrl
`default_nettype wire

// File: inc/cpc_pkg.sv
// package: constants and types for the charger pin control logic
package cpc_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned CLK_MHZ          = 250;         // core clock rate
   localparam int unsigned FAULT_PULSE_US   = 128;         // fault pulse width
   localparam int unsigned FAULT_PULSE_CYC  = FAULT_PULSE_US * CLK_MHZ;  // 32000
   localparam int unsigned SAFETY_MIN       = 27;          // default-mode safety time
   localparam longint unsigned SAFETY_CYC   =
      longint'(SAFETY_MIN) * 64'd60 * 64'd1000000 * longint'(CLK_MHZ);
   localparam int unsigned WDOG_S           = 12;          // watchdog timeout
   localparam longint unsigned WDOG_CYC     =
      longint'(WDOG_S) * 64'd1000000 * longint'(CLK_MHZ);

   // ****************************************************************
   // start-up limits
   // ****************************************************************
   localparam logic [3:0] ILIM_100MA   = 4'h1;   // pc-mode input limit, 100 mA
   localparam logic [3:0] ILIM_NONE    = 4'hF;   // adapter: no input limit
   localparam logic [3:0] ICHG_1A      = 4'h8;   // default charge current, 1 A
   localparam logic [3:0] ICHG_REDUCED = 4'h4;   // warm-pack reduced current

   // temperature zone of the pack
   typedef enum logic [1:0] {
      CPC_T_NORMAL,
      CPC_T_WARM,
      CPC_T_HOT,
      CPC_T_COLD
   } cpc_temp_e;

endpackage : cpc_pkg

// File: inc/cpc_pulse_if.sv
// interface: fault pulse request and output between main logic and pulse timer
`timescale 1ns/10ps
`default_nettype none
interface cpc_pulse_if;
   logic fire;      // one-cycle fault request
   logic active;    // pulse in progress
   modport ctrl  (output fire, input active);
   modport timer (input fire, output active);
endinterface : cpc_pulse_if
`default_nettype wire

// File: core/cpc_pulse_gen.sv
// module: fixed-width fault pulse timer
`timescale 1ns/10ps
`default_nettype none
module cpc_pulse_gen
   import cpc_pkg::*;
#(
   parameter int unsigned PULSE_CYC = FAULT_PULSE_CYC
)(
   input  wire logic   core_clk,
   input  wire logic   rstn,
   cpc_pulse_if.timer  pif
);
   import cpc_pkg::*;

   logic [31:0] cnt_r;   // cycles left in the pulse

   // ****************************************************************
   // counter: a fire while busy neither extends nor cuts the pulse
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 32'h0000_0000;
      end else if (cnt_r != 32'h0000_0000) begin
         cnt_r <= cnt_r - 32'h0000_0001;
      end else if (pif.fire) begin
         cnt_r <= PULSE_CYC[31:0];
      end
   end

   assign pif.active = (cnt_r != 32'h0000_0000);

   // a started pulse stands for at least eight cycles
   a_pulse_width: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(pif.active) |-> pif.active [*8])
      else $error("fault pulse too short");
endmodule : cpc_pulse_gen
`default_nettype wire

// File: testbench/cpc_host_model.sv
// partner model: host side of the pins, indicator pull-up and i2c activity
`timescale 1ns/10ps
`default_nettype none
module cpc_host_model (
   input  wire logic core_clk,
   input  wire logic indicator_o,
   input  wire logic indicator_oe,
   input  wire logic keep_alive,      // host keeps the bus busy
   output logic      indicator_wire,  // resolved open-drain level
   output logic      wdog_kick,       // one-cycle i2c access
   output logic      host_write       // one-cycle i2c write
);
   int tick;   // spacing of keep-alive accesses
   // ****************************************************************
   // open-drain wire, pulled up when nobody drives it
   // ****************************************************************
   assign indicator_wire = indicator_oe ? indicator_o : 1'b1;
   initial begin
      wdog_kick  <= 1'b0;
      host_write = 1'b0;
      tick       <= 0;
   end
   // ****************************************************************
   // one access every 20 cycles while keep_alive is set
   // ****************************************************************
   always @(posedge core_clk) begin
      tick      <= (tick == 19) ? 0 : tick + 1;
      wdog_kick <= #1 keep_alive && (tick == 19);
   end
   // a register write ends default mode
   task automatic write();
      @(posedge core_clk);
      #1 host_write = 1'b1;
      @(posedge core_clk);
      #1 host_write = 1'b0;
   endtask : write
endmodule : cpc_host_model
`default_nettype wire

// File: testbench/charger_pin_control_logic_tb.sv
// testbench: self-checking scenarios for the charger pin control logic
`timescale 1ns/10ps
`default_nettype none
module charger_pin_control_logic_tb;
   import cpc_pkg::*;
   localparam int unsigned     PL = 20;    // shortened fault pulse
   localparam longint unsigned SL = 100;   // shortened safety time
   localparam longint unsigned WL = 50;    // shortened watchdog time
   logic core_clk, rstn, charge_disable_pin, source_select_pin;
   logic pack_temp_cold, pack_temp_hot, pack_temp_warm, fault_event;
   logic charge_done, indicator_en, accessory_en, keep_alive;
   logic wdog_kick, host_write, charging, hi_z_mode, indicator_o;
   logic indicator_oe, accessory_power_output, default_mode;
   logic safety_expired, regs_reset, ind_wire;
   logic [3:0] input_limit, charge_current;
   logic [1:0] temp_status;
   int failures, comparisons;
   // ****************************************************************
   // design, host partner, clock
   // ****************************************************************
   cpc_ctrl #(.SAFETY_LEN(SL), .WDOG_LEN(WL), .PULSE_LEN(PL)) DUT (
      .core_clk(core_clk), .rstn(rstn), .charge_disable_pin(charge_disable_pin),
      .source_select_pin(source_select_pin), .pack_temp_cold(pack_temp_cold),
      .pack_temp_hot(pack_temp_hot), .pack_temp_warm(pack_temp_warm),
      .fault_event(fault_event), .charge_done(charge_done),
      .indicator_en(indicator_en), .accessory_en(accessory_en),
      .wdog_kick(wdog_kick), .host_write(host_write), .charging(charging),
      .hi_z_mode(hi_z_mode), .input_limit(input_limit),
      .charge_current(charge_current), .indicator_o(indicator_o),
      .indicator_oe(indicator_oe), .accessory_power_output(accessory_power_output),
      .default_mode(default_mode), .safety_expired(safety_expired),
      .temp_status(temp_status), .regs_reset(regs_reset));
   cpc_host_model HOST (.core_clk(core_clk), .indicator_o(indicator_o),
      .indicator_oe(indicator_oe), .keep_alive(keep_alive),
      .indicator_wire(ind_wire), .wdog_kick(wdog_kick), .host_write(host_write));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // counts cycles with the indicator wire low
   task automatic count_low(input int n, output int c);
      c = 0;
      repeat (n) begin
         step(1);
         if (ind_wire === 1'b0) c++;
      end
   endtask : count_low
   task automatic do_reset();
      rstn = 1'b0;
      step(12);
      rstn = 1'b1;
      step(5);
   endtask : do_reset
   task automatic complete_run();
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_pins();
      do_reset();
      chk(input_limit, ILIM_NONE);
      chk(charge_current, ICHG_1A);
      source_select_pin = 1'b1;
      step(5);
      chk(input_limit, ILIM_100MA);
      source_select_pin = 1'b0;
      chk(4'(charging), 4'h1);
      charge_disable_pin = 1'b1;
      step(4);
      chk(4'(hi_z_mode), 4'h1);
      chk(4'(charging), 4'h0);
      charge_disable_pin = 1'b0;
      accessory_en = 1'b1;
      step(4);
      chk(4'(charging), 4'h1);
      chk(4'(accessory_power_output), 4'h1);
      accessory_en = 1'b0;
      step(3);
      chk(4'(accessory_power_output), 4'h0);
   endtask : t_pins
   task automatic t_indicator();
      int c;
      do_reset();
      indicator_en = 1'b1;
      step(3);
      chk(4'(ind_wire), 4'h0);
      indicator_en = 1'b0;
      step(3);
      chk(4'(ind_wire), 4'h1);
      indicator_en = 1'b1;
      charge_done = 1'b1;
      step(3);
      chk(4'(ind_wire), 4'h1);
      fault_event = 1'b1;
      step(1);
      fault_event = 1'b0;
      step(5);
      fault_event = 1'b1;
      step(1);
      fault_event = 1'b0;
      count_low(60, c);
      chk(32'(c + 6), 32'(PL));
      indicator_en = 1'b0;
      fault_event = 1'b1;
      step(1);
      fault_event = 1'b0;
      count_low(40, c);
      chk(4'(c), 4'h0);
      charge_done = 1'b0;
   endtask : t_indicator
   task automatic t_temp();
      do_reset();
      pack_temp_hot = 1'b1;
      step(6);
      chk(4'(charging), 4'h0);
      chk(4'(temp_status), 4'h2);
      pack_temp_hot = 1'b0;
      pack_temp_cold = 1'b1;
      step(6);
      chk(4'(charging), 4'h0);
      chk(4'(temp_status), 4'h3);
      pack_temp_cold = 1'b0;
      pack_temp_warm = 1'b1;
      step(6);
      chk(4'(charging), 4'h1);
      chk(charge_current, ICHG_REDUCED);
      chk(4'(temp_status), 4'h1);
      pack_temp_warm = 1'b0;
      HOST.write();
      step(3);
      chk(4'(default_mode), 4'h0);
      pack_temp_hot = 1'b1;
      step(6);
      chk(4'(charging), 4'h1);
      chk(4'(temp_status), 4'h2);
      pack_temp_hot = 1'b0;
      pack_temp_warm = 1'b1;
      step(6);
      chk(charge_current, ICHG_1A);
      pack_temp_warm = 1'b0;
   endtask : t_temp
   task automatic t_watchdog();
      int n;
      n = 0;
      while (regs_reset !== 1'b1 && n < 70) begin
         step(1);
         n++;
      end
      chk(4'(regs_reset), 4'h1);
      step(2);
      chk(4'(default_mode), 4'h1);
      chk(4'(regs_reset), 4'h0);
      chk(4'(safety_expired), 4'h0);
   endtask : t_watchdog
   task automatic t_safety();
      do_reset();
      step(70);
      charge_disable_pin = 1'b1;
      step(4);
      charge_disable_pin = 1'b0;
      step(70);
      chk(4'(safety_expired), 4'h0);
      step(40);
      chk(4'(safety_expired), 4'h1);
      do_reset();
      HOST.write();
      keep_alive = 1'b1;
      step(60);
      charge_disable_pin = 1'b1;
      step(4);
      charge_disable_pin = 1'b0;
      step(60);
      chk(4'(safety_expired), 4'h1);
      keep_alive = 1'b0;
   endtask : t_safety
   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial begin
      failures = 0;
      comparisons = 0;
      {rstn, charge_disable_pin, source_select_pin, fault_event} = 4'h0;
      {pack_temp_cold, pack_temp_hot, pack_temp_warm, charge_done} = 4'h0;
      {indicator_en, accessory_en, keep_alive} = 3'h0;
      t_pins();
      t_indicator();
      t_temp();
      t_watchdog();
      t_safety();
      complete_run();
   end
   initial begin
      #40000;
      failures++;
      complete_run();
   end
endmodule : charger_pin_control_logic_tb
`default_nettype wire
